// ===== verilog/period_match_timer_8bit.sv
// 8-bit period match timer with prescaler, postscaler and APB registers.
// Assumes a synchronous APB master on i_sys_clk and a sleep level from the core.
//
// Notes on behaviour
// - Counting is paced only by the instruction clock, system clock over four.
// - Count and period registers are eight bits wide.
// - Count starts at zero and steps by one per prescaled tick.
// - Six-bit prescaler divides by 1, 4, 16 or 64 per select field.
// - Count compared with period every cycle; equality gives match output only while running and not asleep.
// - Match returns count to zero next tick and clocks postscaler.
// - Software reads and writes count and period directly.
// - Reset clears count and loads period with all ones.
// - Count write or control write clears both scalers; control leaves count.
// - Every device reset clears prescaler and postscaler.
// - Postscaler terminal count sets and holds the match interrupt flag.
// - Flag latches always; interrupt raised only when enable bit set.
// - Four-bit postscale field selects ratios 1:1 through 1:16.
// - Match output is aligned with system clock edges.
// - Sleep stops counting; count and period hold their values.
`timescale 1ns/10ps
`default_nettype none
`include "period_match_timer_8bit_defs.svh"

module period_match_timer_8bit
   import period_match_timer_8bit_pkg::*;
(
   input  wire logic        i_sys_clk,
   input  wire logic        i_resetn,
   input  wire logic        i_sleep,
   input  wire logic        i_psel,
   input  wire logic        i_penable,
   input  wire logic        i_pwrite,
   input  wire logic [11:0] i_paddr,
   input  wire logic [31:0] i_pwdata,
   output logic             o_pready,
   output logic [31:0]      o_prdata,
   output logic             o_pslverr,
   output logic             o_period_match_pulse,
   output logic             o_irq
);

   // ****************************************
   // Bus decode
   // ****************************************
   logic wr_en;
   logic rd_en;
   logic hit;
   assign o_pready  = 1'b1;
   assign hit       = (i_paddr == `OFS_COUNT) || (i_paddr == `OFS_PERIOD) ||
                      (i_paddr == `OFS_CONTROL) || (i_paddr == `OFS_IRQ_FLAG) ||
                      (i_paddr == `OFS_IRQ_ENABLE);
   assign wr_en     = i_psel && i_penable && i_pwrite && hit;
   assign rd_en     = i_psel && !i_penable && !i_pwrite;
   assign o_pslverr = i_psel && i_penable && !hit;

   logic wr_count;
   logic wr_period;
   logic wr_control;
   logic wr_flag;
   logic wr_enable;
   assign wr_count   = wr_en && (i_paddr == `OFS_COUNT);
   assign wr_period  = wr_en && (i_paddr == `OFS_PERIOD);
   assign wr_control = wr_en && (i_paddr == `OFS_CONTROL);
   assign wr_flag    = wr_en && (i_paddr == `OFS_IRQ_FLAG);
   assign wr_enable  = wr_en && (i_paddr == `OFS_IRQ_ENABLE);

   // ****************************************
   // Registers
   // ****************************************
   logic [7:0]     timer_count_r;
   logic [7:0]     timer_period_r;
   timer_control_s timer_control_r;
   logic           match_irq_flag_r;
   logic           match_irq_enable_r;

   always_ff @(posedge i_sys_clk) begin
      if (!i_resetn) begin
         timer_period_r <= `RST_PERIOD;
      end else if (wr_period) begin
         timer_period_r <= i_pwdata[7:0];
      end
   end

   always_ff @(posedge i_sys_clk) begin
      if (!i_resetn) begin
         timer_control_r <= `RST_CONTROL;
      end else if (wr_control) begin
         timer_control_r <= i_pwdata[`CTL_WIDTH-1:0];
      end
   end

   always_ff @(posedge i_sys_clk) begin
      if (!i_resetn) begin
         match_irq_enable_r <= 1'b0;
      end else if (wr_enable) begin
         match_irq_enable_r <= i_pwdata[0];
      end
   end

   // ****************************************
   // Instruction clock and prescaler
   // ****************************************
   // Phase counter makes a one-cycle tick at Fosc/4; no derived clock net
   logic [1:0] phase_r;
   logic       instr_tick;
   always_ff @(posedge i_sys_clk) begin
      if (!i_resetn) begin
         phase_r <= 2'd0;
      end else begin
         phase_r <= phase_r + 2'd1;
      end
   end
   assign instr_tick = (phase_r == 2'(`INSTR_DIV - 1));

   logic       counting;
   logic       scaler_clr;
   logic [5:0] pre_r;
   logic [5:0] pre_last;
   logic       pre_tick;
   assign counting   = timer_control_r.timer_run && !i_sleep;
   assign scaler_clr = wr_count || wr_control;

   always_comb begin
      case (prescale_e'(timer_control_r.prescale_select))
         PRE_DIV1:  pre_last = 6'd0;
         PRE_DIV4:  pre_last = 6'd3;
         PRE_DIV16: pre_last = 6'd15;
         PRE_DIV64: pre_last = 6'd63;
         default:   pre_last = 6'd0;
      endcase
   end

   // Divide by 64 needs six bits; low four mirror the documented prescaler
   always_ff @(posedge i_sys_clk) begin
      if (!i_resetn || scaler_clr) begin
         pre_r <= 6'd0;
      end else if (counting && instr_tick) begin
         pre_r <= (pre_r >= pre_last) ? 6'd0 : pre_r + 6'd1;
      end
   end
   assign pre_tick = counting && instr_tick && (pre_r >= pre_last);

   // ****************************************
   // Count, compare, match
   // ****************************************
   logic equal;
   assign equal = (timer_count_r == timer_period_r);

   always_ff @(posedge i_sys_clk) begin
      if (!i_resetn) begin
         timer_count_r <= `RST_COUNT;
      end else if (wr_count) begin
         timer_count_r <= i_pwdata[7:0];
      end else if (pre_tick) begin
         timer_count_r <= equal ? 8'h00 : timer_count_r + 8'h01;
      end
   end

   // Match holds while the count equals the period, i.e. one scaled period
   logic match_r;
   logic match_rise;
   always_ff @(posedge i_sys_clk) begin
      if (!i_resetn) begin
         match_r <= 1'b0;
      end else begin
         match_r <= equal && counting;
      end
   end
   assign o_period_match_pulse = match_r;
   assign match_rise = equal && counting && !match_r;

   // ****************************************
   // Postscaler and interrupt
   // ****************************************
   logic [3:0] post_r;
   logic       post_term;
   assign post_term = match_rise && (post_r == timer_control_r.postscale_select);
   always_ff @(posedge i_sys_clk) begin
      if (!i_resetn || scaler_clr) begin
         post_r <= 4'h0;
      end else if (match_rise) begin
         post_r <= post_term ? 4'h0 : post_r + 4'h1;
      end
   end

   // Set wins over a write-one-to-clear in the same cycle
   always_ff @(posedge i_sys_clk) begin
      if (!i_resetn) begin
         match_irq_flag_r <= 1'b0;
      end else if (post_term) begin
         match_irq_flag_r <= 1'b1;
      end else if (wr_flag && i_pwdata[0]) begin
         match_irq_flag_r <= 1'b0;
      end
   end
   assign o_irq = match_irq_flag_r && match_irq_enable_r;

   // ****************************************
   // Read data
   // ****************************************
   always_ff @(posedge i_sys_clk) begin
      if (!i_resetn) begin
         o_prdata <= 32'h0000_0000;
      end else if (rd_en) begin
         case (i_paddr)
            `OFS_COUNT:      o_prdata <= {24'h0, timer_count_r};
            `OFS_PERIOD:     o_prdata <= {24'h0, timer_period_r};
            `OFS_CONTROL:    o_prdata <= {25'h0, timer_control_r};
            `OFS_IRQ_FLAG:   o_prdata <= {31'h0, match_irq_flag_r};
            `OFS_IRQ_ENABLE: o_prdata <= {31'h0, match_irq_enable_r};
            default:         o_prdata <= 32'h0000_0000;
         endcase
      end
   end

   // ****************************************
   // Assertion helpers
   // ****************************************
   // Gaps reach 256 cycles, so they are counted rather than unrolled
   logic [8:0] tick_gap_r;
   logic       tick_gap_ok_r;
   logic [8:0] tick_gap_exp;
   logic [8:0] match_len_r;

   // One scaled period: four system clocks times the prescale ratio
   assign tick_gap_exp = 9'(`INSTR_DIV) << {timer_control_r.prescale_select, 1'b0};

   // Gap is only trusted between two ticks of one uninterrupted run
   always_ff @(posedge i_sys_clk) begin
      if (!i_resetn) begin
         tick_gap_r    <= 9'h000;
         tick_gap_ok_r <= 1'b0;
      end else if (scaler_clr || !counting) begin
         tick_gap_r    <= 9'h000;
         tick_gap_ok_r <= 1'b0;
      end else if (pre_tick) begin
         tick_gap_r    <= 9'h001;
         tick_gap_ok_r <= 1'b1;
      end else if (tick_gap_r != 9'h1ff) begin
         tick_gap_r    <= tick_gap_r + 9'h001;
      end
   end

   // Writes may stretch one pulse legally, so they restart the length
   always_ff @(posedge i_sys_clk) begin
      if (!i_resetn) begin
         match_len_r <= 9'h000;
      end else if (!o_period_match_pulse || scaler_clr || wr_count || wr_period) begin
         match_len_r <= 9'h000;
      end else if (match_len_r != 9'h1ff) begin
         match_len_r <= match_len_r + 9'h001;
      end
   end

   // ****************************************
   // Assertions
   // ****************************************
   default clocking cb @(posedge i_sys_clk); endclocking
   default disable iff (!i_resetn);

   // Registers seen by software
   a_period_reset_value: assert property ($rose(i_resetn) |-> timer_period_r == 8'hff)
      else $error("period not all ones after reset");

   a_count_written: assert property (wr_count
         |=> timer_count_r == $past(i_pwdata[7:0]))
      else $error("count write lost");

   a_period_written: assert property (wr_period
         |=> timer_period_r == $past(i_pwdata[7:0]))
      else $error("period write lost");

   // Counting
   a_instr_tick_rate: assert property (instr_tick |=> !instr_tick [*3])
      else $error("instruction tick too fast");

   a_count_wraps_zero: assert property (pre_tick && equal && !wr_count
         |=> timer_count_r == 8'h00)
      else $error("count did not restart on match");

   a_count_steps_one: assert property (pre_tick && !equal && !wr_count
         |=> timer_count_r == $past(timer_count_r) + 8'h01)
      else $error("count did not step by one");

   a_sleep_holds_count: assert property (i_sleep && !wr_count |=> $stable(timer_count_r))
      else $error("count moved in sleep");

   a_period_sleep: assert property (i_sleep && !wr_period |=> $stable(timer_period_r))
      else $error("period moved in sleep");

   a_no_match_sleep: assert property (i_sleep |=> !o_period_match_pulse)
      else $error("match while asleep");

   a_off_no_match: assert property (!timer_control_r.timer_run |=> !o_period_match_pulse)
      else $error("match while timer off");

   a_match_tracks_equal: assert property (counting && equal |=> o_period_match_pulse)
      else $error("match missing on equality");

   a_match_width: assert property (o_period_match_pulse
         |-> match_len_r < tick_gap_exp)
      else $error("match longer than one scaled period");

   a_tick_spacing: assert property (pre_tick && tick_gap_ok_r
         |-> tick_gap_r == tick_gap_exp)
      else $error("prescaled tick spacing wrong");

   a_scalers_cleared: assert property (scaler_clr |=> pre_r == 6'd0 && post_r == 4'h0)
      else $error("scalers not cleared");

   a_ctrl_keeps_count: assert property (wr_control && !pre_tick |=> $stable(timer_count_r))
      else $error("control write moved count");

   // Postscaler and flag
   a_post_steps: assert property (match_rise && !post_term && !scaler_clr
         |=> post_r == $past(post_r) + 4'h1)
      else $error("postscaler did not step on match");

   a_flag_on_term: assert property (post_term |=> match_irq_flag_r)
      else $error("flag not set at terminal count");

   a_flag_sticky: assert property (match_irq_flag_r && !(wr_flag && i_pwdata[0])
         |=> match_irq_flag_r)
      else $error("flag dropped without clear");

   a_flag_needs_term: assert property ($rose(match_irq_flag_r) |-> $past(post_term))
      else $error("flag set without terminal count");

   a_irq_gated: assert property (o_irq == (match_irq_flag_r && match_irq_enable_r))
      else $error("irq not gated by enable");

   c_match_seen:  cover property (o_period_match_pulse);
   c_flag_set:    cover property (post_term);
   c_irq_raised:  cover property ($rose(o_irq));
   c_div64_tick:  cover property (pre_tick && timer_control_r.prescale_select == 2'b11);
   c_sleep_run:   cover property (i_sleep && timer_control_r.timer_run);

endmodule : period_match_timer_8bit
`default_nettype wire

// ===== verilog/period_match_timer_8bit_defs.svh
// Constants for the 8-bit period match timer: offsets, fields, resets, timing.
// Assumes inclusion by bare name from the package and the design module.
`ifndef PERIOD_MATCH_TIMER_8BIT_DEFS_SVH
`define PERIOD_MATCH_TIMER_8BIT_DEFS_SVH

// APB byte offsets
`define OFS_COUNT        12'h000
`define OFS_PERIOD       12'h004
`define OFS_CONTROL      12'h008
`define OFS_IRQ_FLAG     12'h00c
`define OFS_IRQ_ENABLE   12'h010

// Control field positions
`define CTL_PRE_LSB      0
`define CTL_RUN_BIT      2
`define CTL_POST_LSB     3
`define CTL_WIDTH        7

// Reset values
`define RST_COUNT        8'h00
`define RST_PERIOD       8'hff
`define RST_CONTROL      7'h00

// Instruction clock is the system clock divided by four
`define SYS_CLK_MHZ      100
`define INSTR_DIV        4

`endif

// ===== verilog/period_match_timer_8bit_pkg.sv
// Types shared by the 8-bit period match timer.
// Assumes the defs header sits alongside it.
`include "period_match_timer_8bit_defs.svh"

package period_match_timer_8bit_pkg;

   typedef struct packed {
      logic [3:0] postscale_select;
      logic       timer_run;
      logic [1:0] prescale_select;
   } timer_control_s;

   typedef enum logic [1:0] {
      PRE_DIV1  = 2'b00,
      PRE_DIV4  = 2'b01,
      PRE_DIV16 = 2'b10,
      PRE_DIV64 = 2'b11
   } prescale_e;

endpackage : period_match_timer_8bit_pkg

// ===== verification/period_match_timer_8bit_tb_top.sv
// Self-checking bench for the 8-bit period match timer: APB tasks and sequences.
// Assumes the design's defs header is on the include path; assertions sit in the design.
`timescale 1ns/10ps
`default_nettype none
`include "period_match_timer_8bit_defs.svh"

module period_match_timer_8bit_tb_top;
   logic        clk;
   logic        resetn;
   logic        sleep;
   logic        psel;
   logic        penable;
   logic        pwrite;
   logic [11:0] paddr;
   logic [31:0] pwdata;
   logic        pready;
   logic [31:0] prdata;
   logic        pslverr;
   logic        match;
   logic        irq;
   int          n_mismatch = 0;
   int          num_checks = 0;
   logic [31:0] rdat;
   logic        rerr;
   int          w;
   int          g;
   int          n;

   period_match_timer_8bit i_dut (.i_sys_clk(clk), .i_resetn(resetn), .i_sleep(sleep),
      .i_psel(psel), .i_penable(penable), .i_pwrite(pwrite), .i_paddr(paddr),
      .i_pwdata(pwdata), .o_pready(pready), .o_prdata(prdata), .o_pslverr(pslverr),
      .o_period_match_pulse(match), .o_irq(irq));

   initial clk = 1'b0;
   always #5 clk = ~clk;

   // ************************************************
   // Tasks
   // ************************************************
   task automatic check(input logic [31:0] got, input logic [31:0] exp);
      num_checks++;
      if (got !== exp) begin
         n_mismatch++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : check

   task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd);
      int t = 0;
      @(posedge clk);
      psel <= 1'b1; penable <= 1'b0; pwrite <= wr; paddr <= a; pwdata <= wd;
      @(posedge clk);
      penable <= 1'b1;
      @(posedge clk);
      // Slave latency not assumed; the wait ends on ready or after a 100-cycle timeout
      while (pready !== 1'b1 && t < 100) begin
         t++;
         @(posedge clk);
      end
      if (pready !== 1'b1) n_mismatch++;
      rdat = prdata;
      rerr = pslverr;
      psel <= 1'b0; penable <= 1'b0;
   endtask : apb

   task automatic rd_chk(input logic [11:0] a, input logic [31:0] exp);
      apb(1'b0, a, 32'h0);
      check(rdat, exp);
   endtask : rd_chk

   // Width of one match pulse and spacing of two rising edges
   task automatic pulse_times(output int wid, output int gap);
      int t = 0;
      wid = 0; gap = 0;
      while (match !== 1'b1 && t < 3000) begin t++; @(posedge clk); end
      while (match === 1'b1 && wid < 3000) begin wid++; @(posedge clk); end
      gap = wid;
      while (match !== 1'b1 && gap < 3000) begin gap++; @(posedge clk); end
   endtask : pulse_times

   task automatic complete_run;
      $display("checks %0d mismatches %0d", num_checks, n_mismatch);
      if (n_mismatch == 0 && num_checks > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask : complete_run

   // ************************************************
   // Sequence
   // ************************************************
   initial begin
      resetn = 1'b0; sleep = 1'b0; psel = 1'b0; penable = 1'b0;
      pwrite = 1'b0; paddr = 12'h000; pwdata = 32'h0;
      repeat (12) @(posedge clk);
      resetn <= 1'b1;
      rd_chk(`OFS_COUNT, 32'h0);
      rd_chk(`OFS_PERIOD, 32'hff);
      rd_chk(`OFS_CONTROL, 32'h0);
      rd_chk(12'h020, 32'h0);
      check({31'h0, rerr}, 32'h1);
      apb(1'b1, `OFS_PERIOD, 32'h1a5);
      rd_chk(`OFS_PERIOD, 32'ha5);
      apb(1'b1, `OFS_COUNT, 32'h42);
      apb(1'b1, `OFS_CONTROL, 32'h1b);
      repeat (40) @(posedge clk);
      rd_chk(`OFS_COUNT, 32'h42);
      check({31'h0, match}, 32'h0);
      // Counting rate and period wrap for every prescale code
      for (int p = 0; p < 4; p++) begin
         apb(1'b1, `OFS_CONTROL, 32'h0);
         apb(1'b1, `OFS_PERIOD, 32'h3);
         apb(1'b1, `OFS_COUNT, 32'h0);
         apb(1'b1, `OFS_CONTROL, 32'h4 | p);
         pulse_times(w, g);
         check(w, 4 << (2 * p));
         check(g, 16 << (2 * p));
      end
      // Sleep freezes the count and holds the period
      sleep <= 1'b1;
      repeat (3) @(posedge clk);
      apb(1'b0, `OFS_COUNT, 32'h0);
      w = rdat;
      repeat (300) @(posedge clk);
      rd_chk(`OFS_COUNT, w);
      rd_chk(`OFS_PERIOD, 32'h3);
      sleep <= 1'b0;
      // Postscale ratio: irq after N+1 matches
      for (int k = 0; k < 3; k++) begin
         n = (k == 0) ? 0 : (k == 1) ? 3 : 15;
         apb(1'b1, `OFS_CONTROL, 32'h0);
         apb(1'b1, `OFS_IRQ_FLAG, 32'h1);
         apb(1'b1, `OFS_IRQ_ENABLE, 32'h1);
         apb(1'b1, `OFS_COUNT, 32'h0);
         apb(1'b1, `OFS_CONTROL, (n << 3) | 32'h4);
         g = 0; w = 0;
         for (int t = 0; t < 2000 && irq !== 1'b1; t++) begin
            @(posedge clk);
            if (match === 1'b1 && g == 0) w++;
            g = (match === 1'b1);
         end
         check(w, n + 1);
         check({31'h0, irq}, 32'h1);
      end
      // Flag stays latched while masked; W1C clears it
      apb(1'b1, `OFS_CONTROL, 32'h0);
      apb(1'b1, `OFS_IRQ_ENABLE, 32'h0);
      @(posedge clk);
      check({31'h0, irq}, 32'h0);
      rd_chk(`OFS_IRQ_FLAG, 32'h1);
      apb(1'b1, `OFS_IRQ_FLAG, 32'h1);
      rd_chk(`OFS_IRQ_FLAG, 32'h0);
      complete_run();
   end

   // Longest path is about 3.2k cycles
   initial begin
      repeat (60000) @(posedge clk);
      n_mismatch++;
      complete_run();
   end
endmodule : period_match_timer_8bit_tb_top
`default_nettype wire
